// ### src/ctt_pkg.sv
package ctt_pkg;

  // Register byte addresses (each register one aligned word)
  localparam logic [7:0] ADDR_T0_COUNT  = 8'h00;
  localparam logic [7:0] ADDR_T0_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_T0_RUN    = 8'h08;
  localparam logic [7:0] ADDR_T1_COUNT  = 8'h10;
  localparam logic [7:0] ADDR_T1_CTRL   = 8'h14;
  localparam logic [7:0] ADDR_T1_RUN    = 8'h18;
  localparam logic [7:0] ADDR_T2_COUNT  = 8'h20;
  localparam logic [7:0] ADDR_T2_CTRL   = 8'h24;
  localparam logic [7:0] ADDR_T2_RUN    = 8'h28;
  localparam logic [7:0] ADDR_INT_EN    = 8'h30;
  localparam logic [7:0] ADDR_INT_FLAGS = 8'h34;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h38;

  // Register indices as printed
  localparam int IDX_T0_COUNT = 'h00;
  localparam int IDX_INT_EN   = 'h0C;

  // Control field positions
  localparam int CTL_SEL_LSB  = 0;
  localparam int CTL_RELOAD   = 4;
  localparam int CTL_TONE     = 5;
  localparam int CTL_STOP_LSB = 6;

  // Reset values of the control registers
  localparam logic [7:0] RST_T0_CTRL = 8'h3E;
  localparam logic [7:0] RST_T1_CTRL = 8'h1E;
  // Timer2 code 1110 picks fast tap 3, with reload set
  localparam logic [7:0] RST_T2_CTRL = 8'h1E;

  // Interrupt bit positions
  localparam int IRQ_T2 = 0;
  localparam int IRQ_T1 = 1;
  localparam int IRQ_T0 = 2;

  // Divider chain widths
  localparam int SLOW_W = 14;
  localparam int FAST_W = 9;

  // Slow clock period and prescale count from pclk (32768 Hz nominal)
  localparam int SLOW_HZ      = 32768;
  localparam int PCLK_HZ      = 100000000;
  localparam int SLOW_PRE_CYC = PCLK_HZ / (2 * SLOW_HZ);

  // Stop modes
  typedef enum logic [1:0] {
    CTT_STOP_OFF  = 2'b00,
    CTT_STOP_T2OV = 2'b01,
    CTT_STOP_EXT  = 2'b10,
    CTT_STOP_T2CK = 2'b11
  } ctt_stop_t;

  // Memory space sizes
  localparam int SFR_BYTES = 64;
  localparam int RAM_BYTES = 128;

endpackage

// ### src/ctt_timers.sv
`timescale 1ns/1ps
`default_nettype none
module ctt_timers
  import ctt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        fast_osc_en,
  input  wire logic        external_clock_input,
  output logic             timer0_tone_output,
  output logic             irq,
  output logic      [1:0]  irq_source
);

  ////////////////////////////////////////////////////////////////////////
  // Tap selection: returns the chosen enable pulse for one timer
  function automatic logic pick(input logic [3:0] sel,
                                input logic casc,
                                input logic [SLOW_W-1:0] st,
                                input logic [FAST_W:0] ft,
                                input logic is_t2);
    logic r;
    r = 1'b0;
    if (sel[3:1] == 3'b000)
      r = casc;
    else if (sel[3:1] == 3'b001)
      r = st[13];
    else if (sel[3:2] == 2'b01)
      r = st[11 - 2 * sel[1:0]];
    else if (is_t2)
      r = ft[9 - sel[2:0]];
    else
      r = ft[7 - sel[2:0]];
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers for the external clock and fast oscillator tick
  logic [1:0] ext_sync;
  logic [1:0] fast_sync;
  logic       ext_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sync  <= 2'b00;
      fast_sync <= 2'b00;
      ext_prev  <= 1'b0;
    end else begin
      ext_sync  <= {ext_sync[0], external_clock_input};
      fast_sync <= {fast_sync[0], fast_osc_en};
      ext_prev  <= ext_sync[1];
    end
  end

  wire ext_rise = ext_sync[1] & ~ext_prev;
  wire fast_tick = fast_sync[1];

  ////////////////////////////////////////////////////////////////////////
  // Divider chains; a tap pulses when its bit falls (one full period)
  logic [15:0]       slow_pre;
  logic [SLOW_W-1:0] slow_cnt;
  logic [FAST_W-1:0] fast_cnt;
  wire               slow_tick = (slow_pre == 16'(SLOW_PRE_CYC - 1));
  wire [SLOW_W-1:0]  slow_next = slow_cnt + 14'h0001;
  wire [FAST_W-1:0]  fast_next = fast_cnt + 9'h001;
  wire [SLOW_W-1:0]  slow_tap  = {SLOW_W{slow_tick}} & slow_cnt & ~slow_next;
  wire [FAST_W:0]    fast_tap  = {FAST_W+1{fast_tick}} &
                                 {fast_cnt & ~fast_next, 1'b1};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_pre <= 16'h0000;
      slow_cnt <= 14'h0000;
      fast_cnt <= 9'h000;
    end else begin
      slow_pre <= slow_tick ? 16'h0000 : slow_pre + 16'h0001;
      if (slow_tick)
        slow_cnt <= slow_next;
      if (fast_tick)
        fast_cnt <= fast_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0] count   [3];
  logic [7:0] preload [3];
  logic [7:0] ctrl    [3];
  logic [2:0] run;
  logic [7:0] int_en;
  logic [2:0] flags;
  logic [2:0] irq_mask;
  logic       t0_halted;

  ////////////////////////////////////////////////////////////////////////
  // APB decode: zero-wait, unmapped reads zero and flag an error
  wire acc   = psel & penable;
  wire wr    = acc & pwrite & pstrb[0];
  wire hit_c0 = (paddr == ADDR_T0_COUNT);
  wire hit_k0 = (paddr == ADDR_T0_CTRL);
  wire hit_r0 = (paddr == ADDR_T0_RUN);
  wire hit_c1 = (paddr == ADDR_T1_COUNT);
  wire hit_k1 = (paddr == ADDR_T1_CTRL);
  wire hit_r1 = (paddr == ADDR_T1_RUN);
  wire hit_c2 = (paddr == ADDR_T2_COUNT);
  wire hit_k2 = (paddr == ADDR_T2_CTRL);
  wire hit_r2 = (paddr == ADDR_T2_RUN);
  wire hit_ie = (paddr == ADDR_INT_EN);
  wire hit_if = (paddr == ADDR_INT_FLAGS);
  wire hit_im = (paddr == ADDR_IRQ_MASK);
  wire [2:0] hit_c = {hit_c2, hit_c1, hit_c0};
  wire [2:0] hit_k = {hit_k2, hit_k1, hit_k0};
  wire [2:0] hit_r = {hit_r2, hit_r1, hit_r0};
  // Everything decoded must sit inside the 64-byte register space
  wire in_space = (paddr < 8'(SFR_BYTES));
  wire mapped = in_space & (|{hit_c, hit_k, hit_r, hit_ie, hit_if, hit_im});

  logic [7:0] rd_byte;
  always_comb begin
    if (hit_c0)      rd_byte = count[0];
    else if (hit_k0) rd_byte = ctrl[0];
    else if (hit_r0) rd_byte = {7'h00, run[0]};
    else if (hit_c1) rd_byte = count[1];
    else if (hit_k1) rd_byte = ctrl[1];
    else if (hit_r1) rd_byte = {7'h00, run[1]};
    else if (hit_c2) rd_byte = count[2];
    else if (hit_k2) rd_byte = ctrl[2];
    else if (hit_r2) rd_byte = {7'h00, run[2]};
    else if (hit_ie) rd_byte = int_en;
    else if (hit_if) rd_byte = {5'h00, flags};
    else if (hit_im) rd_byte = {5'h00, irq_mask};
    else             rd_byte = 8'h00;
  end

  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // Read data registered on the setup cycle so it stands in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite)
      prdata <= {24'h000000, rd_byte};
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock selection per timer, cascade taken from the previous count bit 7
  logic [2:0] tick;
  logic [2:0] ovf;
  logic [2:0] msb_fall;
  logic       t0_stop_evt;

  always_comb begin
    for (int i = 0; i < 3; i++)
      msb_fall[i] = 1'b0;
    tick[0] = pick(ctrl[0][3:0], ext_rise, slow_tap, fast_tap, 1'b0);
    tick[1] = pick(ctrl[1][3:0], msb_fall[0], slow_tap, fast_tap, 1'b0);
    tick[2] = pick(ctrl[2][3:0], msb_fall[1], slow_tap, fast_tap, 1'b1);
    for (int i = 0; i < 3; i++)
      ovf[i] = tick[i] & run[i] & (count[i] == 8'hFF);
  end

  // Cascade edge: bit 7 falling means a full period of the upstream timer
  logic [1:0] msb_prev;
  wire  [1:0] casc_fall = msb_prev & ~{count[1][7], count[0][7]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      msb_prev <= 2'b00;
    else
      msb_prev <= {count[1][7], count[0][7]};
  end

  // Cascade ticks come one cycle after the upstream bit falls
  logic [2:0] eff_tick;
  assign eff_tick[0] = tick[0];
  assign eff_tick[1] = (ctrl[1][3:1] == 3'b000) ? casc_fall[0] : tick[1];
  assign eff_tick[2] = (ctrl[2][3:1] == 3'b000) ? casc_fall[1] : tick[2];

  wire [2:0] eff_ovf;
  assign eff_ovf[0] = eff_tick[0] & run[0] & ~t0_halted & (count[0] == 8'hFF);
  assign eff_ovf[1] = eff_tick[1] & run[1] & (count[1] == 8'hFF);
  assign eff_ovf[2] = eff_tick[2] & run[2] & (count[2] == 8'hFF);

  ////////////////////////////////////////////////////////////////////////
  // Timer0 stop modes
  ctt_stop_t stop_mode;
  assign stop_mode = ctt_stop_t'(ctrl[0][7:6]);
  logic      stop_armed;

  always_comb begin
    case (stop_mode)
      CTT_STOP_T2OV: t0_stop_evt = eff_ovf[2];
      CTT_STOP_EXT:  t0_stop_evt = stop_armed & ext_rise;
      CTT_STOP_T2CK: t0_stop_evt = stop_armed & eff_tick[2];
      default:       t0_stop_evt = 1'b0;
    endcase
  end

  // First edge arms; the next edge closes one full cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_armed <= 1'b0;
      t0_halted  <= 1'b0;
    end else if (stop_mode == CTT_STOP_OFF || (wr & hit_k0)) begin
      stop_armed <= 1'b0;
      t0_halted  <= 1'b0;
    end else begin
      if ((stop_mode == CTT_STOP_EXT && ext_rise) ||
          (stop_mode == CTT_STOP_T2CK && eff_tick[2]))
        stop_armed <= 1'b1;
      if (t0_stop_evt)
        t0_halted <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counters, preload and control registers
  wire [7:0] wbyte = pwdata[7:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) begin
        count[i]   <= 8'h00;
        preload[i] <= 8'h00;
      end
      ctrl[0] <= RST_T0_CTRL;
      ctrl[1] <= RST_T1_CTRL;
      ctrl[2] <= RST_T2_CTRL;
      run     <= 3'b000;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr & hit_c[i]) begin
          preload[i] <= wbyte;
          if (!run[i])
            count[i] <= wbyte;
        end else if (eff_ovf[i]) begin
          count[i] <= preload[i];
          if (!ctrl[i][CTL_RELOAD])
            run[i] <= 1'b0;
        end else if (eff_tick[i] & run[i] & ~(i == 0 && t0_halted)) begin
          count[i] <= count[i] + 8'h01;
        end
        if (wr & hit_k[i])
          ctrl[i] <= wbyte;
        if (wr & hit_r[i])
          run[i] <= wbyte[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt enables, flags and mask
  wire       t0_stop_mode = (stop_mode != CTT_STOP_OFF);
  wire [2:0] events = {eff_ovf[0] | (t0_stop_mode & t0_stop_evt),
                       eff_ovf[1], eff_ovf[2]};
  wire [2:0] flag_set = events & int_en[2:0];
  wire [2:0] flag_clr = (wr & hit_if) ? ~wbyte[2:0] : 3'b000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_en   <= 8'h00;
      flags    <= 3'b000;
      irq_mask <= 3'b000;
    end else begin
      if (wr & hit_ie)
        int_en <= wbyte;
      if (wr & hit_im)
        irq_mask <= wbyte[2:0];
      // Set wins over a clear in the same cycle
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Tone output and interrupt request with fixed priority
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      timer0_tone_output <= 1'b0;
    else if (!ctrl[0][CTL_TONE])
      timer0_tone_output <= 1'b0;
    else if (eff_ovf[0])
      timer0_tone_output <= ~timer0_tone_output;
  end

  wire [2:0] pend = flags & irq_mask;
  assign irq = |pend;
  assign irq_source = pend[IRQ_T2] ? 2'd2 :
                      pend[IRQ_T1] ? 2'd1 :
                      pend[IRQ_T0] ? 2'd0 : 2'd3;

endmodule
`default_nettype wire

// ### testbench/ctt_timers_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ctt_chk
  import ctt_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timer0_tone_output,
  input wire logic        irq,
  input wire logic [1:0]  irq_source
);
  // Word map has a hole at every offset ending in C
  wire  wr_acc = psel && penable && pwrite;
  wire  mapped = paddr <= ADDR_IRQ_MASK && paddr[3:2] != 2'h3 &&
                 paddr[1:0] == 2'h0;
  wire  rd_set = psel && !penable && !pwrite;
  wire  en_wr  = wr_acc && paddr == ADDR_INT_EN && |pwdata[2:0];
  wire  run_wr = wr_acc && paddr == ADDR_T0_RUN && pwdata[0];
  logic en_seen;
  logic run_seen;

  // Sticky: irq and tone stay quiet until software arms them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_seen  <= 1'b0;
      run_seen <= 1'b0;
    end else begin
      en_seen  <= en_seen | en_wr;
      run_seen <= run_seen | run_wr;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////
  AST_READY:
    assert property (pready) else $error("no ready");
  AST_ERR_PHASE:
    assert property (pslverr |-> psel && penable) else $error("stray err");
  AST_ERR_HOLE:
    assert property (psel && penable && !mapped |-> pslverr)
      else $error("hole not refused");
  AST_RD_HOLD:
    assert property (!rd_set |=> $stable(prdata)) else $error("rdata moved");
  AST_RD_HOLE:
    assert property (rd_set && !mapped |=> prdata == 32'h0)
      else $error("hole read");
  AST_IRQ_SRC:
    assert property (irq |-> irq_source != 2'h3) else $error("no source");
  AST_SRC_IDLE:
    assert property (!irq |-> irq_source == 2'h3) else $error("stray source");
  AST_IRQ_QUIET:
    assert property (!en_seen |-> !irq && irq_source == 2'h3)
      else $error("early irq");
  AST_TONE_QUIET:
    assert property (!run_seen |=> $stable(timer0_tone_output))
      else $error("early tone");
endmodule
`default_nettype wire

// ### testbench/test_cascaded_triple_timer.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("unexpected at %0t: %h vs %h", $time, g, e); \
  end \
end
module test_cascaded_triple_timer
  import ctt_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        fast_osc_en;
  logic        external_clock_input;
  logic        timer0_tone_output;
  logic        irq;
  logic [1:0]  irq_source;
  logic        last_err;
  logic [31:0] q;
  int          err_total;
  int          samples_checked;

  ctt_timers dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fast_osc_en(fast_osc_en),
    .external_clock_input(external_clock_input),
    .timer0_tone_output(timer0_tone_output),
    .irq(irq), .irq_source(irq_source)
  );

  // Free-running 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  ////////////////////////////////////////
  task automatic give_verdict();
    if (err_total == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // One APB transfer; ends a step after the edge so outputs have landed
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      err_total++;
      give_verdict();
    end
    q = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    `CHK(q, {24'h0, e})
  endtask

  // Pin clock cycles, slow enough for the synchroniser
  task automatic pulse(input int k);
    repeat (k) begin
      @(posedge pclk);
      external_clock_input <= 1'b1;
      idle(4);
      external_clock_input <= 1'b0;
      idle(4);
    end
  endtask

  ////////////////////////////////////////
  initial begin
    int t;
    int c;
    int d;
    logic [7:0] v0;
    logic       tb;
    logic [7:0] sm [4] = '{8'h7F, 8'hBF, 8'hFF, 8'h3F};
    {presetn, psel, penable, pwrite, external_clock_input} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    fast_osc_en = 1'b1;
    err_total = 0;
    samples_checked = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk(ADDR_T0_CTRL, 8'h3E);
    chk(ADDR_T1_CTRL, 8'h1E);
    chk(ADDR_T2_CTRL, 8'h1E);
    chk(ADDR_INT_EN, 8'h00);
    chk(8'h3C, 8'h00);
    `CHK(last_err, 1'b1)
    // Pin clock: counted when running, preload write leaves count alone
    wr(ADDR_T0_CTRL, 8'h30);
    wr(ADDR_T0_COUNT, 8'h10);
    wr(ADDR_T0_RUN, 8'h01);
    pulse(3);
    idle(6);
    chk(ADDR_T0_COUNT, 8'h13);
    wr(ADDR_T0_COUNT, 8'h80);
    chk(ADDR_T0_COUNT, 8'h13);
    wr(ADDR_T0_RUN, 8'h00);
    pulse(2);
    chk(ADDR_T0_COUNT, 8'h13);
    // Every fast tap: ticks over a 203-cycle span, jitter of two allowed
    for (t = 0; t < 3; t++) begin
      for (c = 8; c < 16; c++) begin
        wr(8'(t * 16 + 4), 8'(8'h10 + c));
        // Start from zero so no overflow reloads inside the span
        wr(8'(t * 16), 8'h00);
        wr(8'(t * 16 + 8), 8'h01);
        xfer(1'b0, 8'(t * 16), 8'h00);
        v0 = q[7:0];
        idle(200);
        xfer(1'b0, 8'(t * 16), 8'h00);
        v0 = q[7:0] - v0;
        d = int'(v0) - 203 / (1 << ((t == 2 ? 17 : 15) - c));
        `CHK(d >= -2 && d <= 2, 1'b1)
        wr(8'(t * 16 + 8), 8'h00);
      end
    end
    // Cascade: upstream bit 7 falling steps the next timer
    wr(ADDR_T0_CTRL, 8'h3F);
    wr(ADDR_T0_COUNT, 8'h00);
    wr(ADDR_T1_CTRL, 8'h10);
    wr(ADDR_T1_COUNT, 8'h7F);
    wr(ADDR_T1_RUN, 8'h01);
    wr(ADDR_T0_RUN, 8'h01);
    idle(300);
    chk(ADDR_T1_COUNT, 8'h80);
    wr(ADDR_T0_RUN, 8'h00);
    wr(ADDR_T1_RUN, 8'h00);
    wr(ADDR_T1_CTRL, 8'h1F);
    wr(ADDR_T1_COUNT, 8'h7F);
    wr(ADDR_T2_CTRL, 8'h10);
    wr(ADDR_T2_COUNT, 8'h00);
    wr(ADDR_T2_RUN, 8'h01);
    wr(ADDR_T1_RUN, 8'h01);
    idle(200);
    chk(ADDR_T2_COUNT, 8'h01);
    // One-shot overflows, tone, priority, clear and mask
    wr(ADDR_T1_RUN, 8'h00);
    wr(ADDR_T2_RUN, 8'h00);
    wr(ADDR_T0_CTRL, 8'h2F);
    wr(ADDR_T1_CTRL, 8'h0F);
    wr(ADDR_T0_COUNT, 8'hF0);
    wr(ADDR_T1_COUNT, 8'hF8);
    wr(ADDR_INT_EN, 8'h07);
    wr(ADDR_IRQ_MASK, 8'h07);
    tb = timer0_tone_output;
    wr(ADDR_T1_RUN, 8'h01);
    wr(ADDR_T0_RUN, 8'h01);
    idle(40);
    chk(ADDR_T0_RUN, 8'h00);
    chk(ADDR_INT_FLAGS, 8'h06);
    `CHK(timer0_tone_output, ~tb)
    `CHK(irq_source, 2'h1)
    wr(ADDR_INT_FLAGS, 8'h05);
    `CHK(irq_source, 2'h0)
    wr(ADDR_IRQ_MASK, 8'h00);
    `CHK(irq, 1'b0)
    wr(ADDR_IRQ_MASK, 8'h07);
    `CHK(irq, 1'b1)
    // Reload keeps T2 cycling near its preload; T2 outranks T0
    wr(ADDR_T2_CTRL, 8'h1F);
    wr(ADDR_T2_COUNT, 8'hFC);
    wr(ADDR_T2_RUN, 8'h01);
    wr(ADDR_T2_COUNT, 8'hFC);
    idle(60);
    `CHK(irq_source, 2'h2)
    chk(ADDR_INT_FLAGS, 8'h05);
    xfer(1'b0, ADDR_T2_COUNT, 8'h00);
    `CHK(q[7:2], 6'h3F)
    // Stop modes: three halt Timer0, mode off lets it run
    for (c = 0; c < 4; c++) begin
      wr(ADDR_T0_CTRL, sm[c]);
      wr(ADDR_T0_RUN, 8'h01);
      pulse(2);
      xfer(1'b0, ADDR_T0_COUNT, 8'h00);
      v0 = q[7:0];
      idle(20);
      xfer(1'b0, ADDR_T0_COUNT, 8'h00);
      `CHK(q[7:0] == v0, c < 3)
    end
    give_verdict();
  end
endmodule

bind ctt_timers ctt_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .timer0_tone_output(timer0_tone_output),
  .irq(irq), .irq_source(irq_source)
);
`default_nettype wire
